// ### verilog/tte_top.sv
/*
 * tie-off handling, apb register file, interrupt and per buffer unit event outputs.
 * assumes straps come from pins (synchronised here), traffic strobes from logic on clk,
 * and an apb master that holds each request until pready.
 */
`default_nettype none
`include "tte_defs.svh"
module tte_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // tie-offs
    input wire logic cfg_cttw,
    input wire logic dft_gate_bypass,
    input wire logic integ_unlock,
    input wire logic sec_debug_permit,
    input wire logic scan_hold,
    input wire logic cfg_normalise,
    input wire logic [1:0] barrier_inhibit,
    // buffer unit traffic
    input wire logic [1:0] wr_txn,
    input wire logic [1:0] rd_txn,
    input wire logic [1:0] wr_alloc,
    input wire logic [1:0] rd_alloc,
    input wire logic [1:0] txn_secure,
    input wire logic [1:0] barrier_gen,
    input wire logic [1:0] barrier_up,
    output logic [1:0] barrier_out,
    // clock gating
    output logic clk_gate_en,
    // events
    output logic [1:0] ev_tick,
    output logic [1:0] ev_div,
    output logic [1:0] ev_wr,
    output logic [1:0] ev_rd,
    output logic [1:0] ev_wrf,
    output logic [1:0] ev_rdf,
    // interrupt
    output logic irq
);
    import tte_pkg::*;

    localparam int NT = `TTE_NUM_UNIT;

    logic [6+NT-1:0] strap_s;
    logic cttw_s, bypass_s, unlock_s, permit_s, scanh_s, norm_s;
    logic [NT-1:0] inhib_s;

    tte_sync2 #(.W(6 + NT)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({barrier_inhibit, cfg_normalise, scan_hold, sec_debug_permit, integ_unlock,
            dft_gate_bypass, cfg_cttw}),
        .q(strap_s)
    );

    assign {inhib_s, norm_s, scanh_s, permit_s, unlock_s, bypass_s, cttw_s} = strap_s;

    // registers
    tte_cap_t cap_r, cap_nxt;
    logic [1:0] cap_cnt_r, cap_cnt_nxt;
    logic aux_r, aux_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] status_r, status_nxt;
    logic [31:0] mask_r, mask_nxt;
    logic [31:0] integ_r, integ_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt;
    logic cg_r, cg_nxt;
    logic clr_r, clr_nxt;

    logic acc, wr, refused, mapped;
    logic [31:0] wmask, rdata;
    logic [31:0] cnt [NT];
    logic [NT-1:0] ovf;

    // one wait state: the answer comes in the second access cycle
    assign acc = psel & penable & ~pready_r;
    // non-secure is pprot[1] high
    assign refused = (paddr == `TTE_OFF_INTEG) & pprot[1] & ~unlock_s;
    assign wr = acc & pwrite & mapped & ~refused;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        mapped = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            `TTE_OFF_ID0: begin
                // recorded only: nothing else in the block reads this strap
                rdata[`TTE_ID0_CTTW] = cttw_s;
                rdata[`TTE_ID0_SCAN] = scanh_s;
            end
            `TTE_OFF_AUX: rdata[`TTE_AUX_NORM] = aux_r;
            `TTE_OFF_CTRL: rdata = ctrl_r;
            `TTE_OFF_STATUS: rdata = status_r;
            `TTE_OFF_MASK: rdata = mask_r;
            `TTE_OFF_CNT0: rdata = cnt[0];
            `TTE_OFF_CNT1: rdata = cnt[1];
            `TTE_OFF_INTEG: rdata = refused ? 32'h0000_0000 : integ_r;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        pready_nxt = acc;
        pslverr_nxt = acc & (~mapped | refused);
        prdata_nxt = (acc && !pwrite && mapped && !refused) ? rdata : 32'h0000_0000;

        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        integ_nxt = integ_r;
        clr_nxt = 1'b0;
        if (wr && paddr == `TTE_OFF_CTRL) begin
            ctrl_nxt = (ctrl_r & ~wmask) | (pwdata & wmask);
            // clear is self-resetting so a stuck bit cannot freeze the counters
            ctrl_nxt[`TTE_CTRL_CLR] = 1'b0;
            clr_nxt = pwdata[`TTE_CTRL_CLR] & pstrb[0];
        end
        if (wr && paddr == `TTE_OFF_MASK) begin
            mask_nxt = (mask_r & ~wmask) | (pwdata & wmask);
        end
        if (wr && paddr == `TTE_OFF_INTEG) begin
            integ_nxt = (integ_r & ~wmask) | (pwdata & wmask);
        end

        // set wins over a simultaneous write-one-to-clear
        status_nxt = status_r;
        if (wr && paddr == `TTE_OFF_STATUS) begin
            status_nxt = status_r & ~(pwdata & wmask);
        end
        status_nxt[NT-1:0] = status_nxt[NT-1:0] | ovf;
        status_nxt[`TTE_ST_REFUSED] = status_nxt[`TTE_ST_REFUSED] | (acc & refused);
        status_nxt[31:3] = 29'h0;
        irq_nxt = |(status_r & mask_r);

        // bypass forces every architectural gate open
        cg_nxt = ctrl_r[`TTE_CTRL_CGEN] | bypass_s;
    end

    // normalise bit: wait for the synchroniser to fill, then load the strap once
    always_comb begin
        cap_nxt = cap_r;
        cap_cnt_nxt = cap_cnt_r;
        aux_nxt = aux_r;
        case (cap_r)
            TTE_CAP_SYNC: begin
                cap_cnt_nxt = cap_cnt_r + 2'h1;
                if (cap_cnt_r == `TTE_SYNC_LAT - 2'h1) begin
                    cap_nxt = TTE_CAP_LOAD;
                end
            end
            TTE_CAP_LOAD: begin
                aux_nxt = norm_s;
                cap_nxt = TTE_CAP_RUN;
            end
            TTE_CAP_RUN: begin
                if (wr && paddr == `TTE_OFF_AUX && pstrb[0]) begin
                    aux_nxt = pwdata[`TTE_AUX_NORM];
                end
            end
            default: cap_nxt = TTE_CAP_SYNC;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_r <= TTE_CAP_SYNC;
            cap_cnt_r <= 2'h0;
            aux_r <= 1'b0;
        end else begin
            cap_r <= cap_nxt;
            cap_cnt_r <= cap_cnt_nxt;
            aux_r <= aux_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `TTE_CTRL_RST;
            status_r <= 32'h0000_0000;
            mask_r <= `TTE_MASK_RST;
            integ_r <= `TTE_INTEG_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
            cg_r <= 1'b1;
            clr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            integ_r <= integ_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
            cg_r <= cg_nxt;
            clr_r <= clr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign clk_gate_en = cg_r;

    // secure debug permit is trusted as driven by the system's trace logic
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_unit
            tte_unit_events u_ev (
                .clk(clk),
                .rst_n(rst_n),
                .wr_txn(wr_txn[gi]),
                .rd_txn(rd_txn[gi]),
                .wr_alloc(wr_alloc[gi]),
                .rd_alloc(rd_alloc[gi]),
                .txn_secure(txn_secure[gi]),
                .barrier_gen(barrier_gen[gi]),
                .barrier_up(barrier_up[gi]),
                .barrier_inhibit(inhib_s[gi]),
                .barrier_out(barrier_out[gi]),
                .cnt_en(ctrl_r[`TTE_CTRL_CEN]),
                .cnt_clr(clr_r),
                .cnt_sel(tte_evsel_t'(ctrl_r[`TTE_CTRL_SEL_HI:`TTE_CTRL_SEL_LO])),
                .secure_permit(permit_s),
                .cnt(cnt[gi]),
                .cnt_ovf(ovf[gi]),
                .ev_tick(ev_tick[gi]),
                .ev_div(ev_div[gi]),
                .ev_wr(ev_wr[gi]),
                .ev_rd(ev_rd[gi]),
                .ev_wrf(ev_wrf[gi]),
                .ev_rdf(ev_rdf[gi])
            );
        end
    endgenerate

    sequence s_acc_start;
        psel && penable && !pready;
    endsequence

    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
        s_acc_start |=> pready ##1 !pready)
        else $error("apb answer not after one wait state");
    a_integ_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        (s_acc_start and (paddr == `TTE_OFF_INTEG && pprot[1] && !unlock_s))
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("non-secure integration access not refused");
    a_norm_load: assert property (@(posedge clk) disable iff (!rst_n)
        cap_r == TTE_CAP_LOAD |=> aux_r == $past(norm_s))
        else $error("normalise bit not loaded from strap");
    a_bypass_gate: assert property (@(posedge clk) disable iff (!rst_n)
        bypass_s |=> clk_gate_en)
        else $error("clock gate not bypassed");
    a_cttw_read: assert property (@(posedge clk) disable iff (!rst_n)
        (s_acc_start and (!pwrite && paddr == `TTE_OFF_ID0))
        |=> prdata[`TTE_ID0_CTTW] == $past(cttw_s))
        else $error("identification register misreports coherent walk strap");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        |(status_r & mask_r) |=> irq)
        else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire

// ### verilog/tte_defs.svh
/*
 * constants for the translation tie-off and event block: register byte offsets,
 * field positions, reset values and timing counts.
 * assumes a 32-bit apb slave decoding paddr[7:0] and a 10 MHz system clock.
 */
// Functional notes
// - coherent-walk strap changes no memory access; it is only recorded for software.
// - coherent-walk strap value is readable in the first identification register.
// - clock gate bypass input high bypasses all architectural clock gates.
// - non-secure integration register access allowed only while unlock input is high.
// - inhibit low: unit generates own barriers and forwards every upstream barrier.
// - inhibit high: unit never originates barriers but still forwards upstream ones.
// - at reset the normalise bit loads the level of the normalise strap.
// - each buffer unit pulses a tick event on every one of its clock cycles.
// - each buffer unit pulses a divided tick event on every 64th clock cycle.
// - each buffer unit signals an event for every write transaction passing through.
// - each buffer unit signals an event for every read transaction passing through.
// - each buffer unit signals a write refill event on write-caused lookaside allocation.
// - each buffer unit signals a read refill event on read-caused lookaside allocation.
// - counters count secure events only while secure debug permit is high.
`ifndef TTE_DEFS_SVH
`define TTE_DEFS_SVH

`define TTE_NUM_UNIT 2
`define TTE_OFF_ID0 8'h00
`define TTE_OFF_AUX 8'h04
`define TTE_OFF_CTRL 8'h08
`define TTE_OFF_STATUS 8'h0c
`define TTE_OFF_MASK 8'h10
`define TTE_OFF_CNT0 8'h14
`define TTE_OFF_CNT1 8'h18
`define TTE_OFF_INTEG 8'h20

`define TTE_ID0_CTTW 0
`define TTE_ID0_SCAN 1
`define TTE_AUX_NORM 0
`define TTE_CTRL_SEL_LO 0
`define TTE_CTRL_SEL_HI 2
`define TTE_CTRL_CEN 3
`define TTE_CTRL_CLR 4
`define TTE_CTRL_CGEN 5
`define TTE_ST_REFUSED 2

`define TTE_CTRL_RST 32'h0000_0020
`define TTE_MASK_RST 32'h0000_0000
`define TTE_INTEG_RST 32'h0000_0000

`define TTE_DIV_RATIO 64
`define TTE_DIV_LAST 6'h3f
`define TTE_SYNC_LAT 2'h2

`endif

// ### verilog/tte_pkg.sv
/*
 * types shared by the event block files.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none
package tte_pkg;
    typedef enum logic [2:0] {
        TTE_EV_TICK = 3'h0,
        TTE_EV_DIV = 3'h1,
        TTE_EV_WR = 3'h2,
        TTE_EV_RD = 3'h3,
        TTE_EV_WRF = 3'h4,
        TTE_EV_RDF = 3'h5
    } tte_evsel_t;

    typedef enum logic [1:0] {
        TTE_CAP_SYNC = 2'h0,
        TTE_CAP_LOAD = 2'h1,
        TTE_CAP_RUN = 2'h2
    } tte_cap_t;
endpackage
`default_nettype wire

// ### verilog/tte_sync2.sv
/*
 * two flip-flop synchroniser for a bundle of static strap levels.
 * assumes the bits are quasi-static, so per-bit skew is harmless.
 */
`default_nettype none
module tte_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] q_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_nxt;

    always_comb begin
        s1_nxt = d;
        q_nxt = s1_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ### verilog/tte_tbu_events.sv
/*
 * per buffer unit event pulses, barrier forwarding and one selectable event counter.
 * assumes transaction strobes are one-cycle handshake pulses on the same clock.
 */
`default_nettype none
`include "tte_defs.svh"
module tte_unit_events (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // traffic
    input wire logic wr_txn,
    input wire logic rd_txn,
    input wire logic wr_alloc,
    input wire logic rd_alloc,
    input wire logic txn_secure,
    // barriers
    input wire logic barrier_gen,
    input wire logic barrier_up,
    input wire logic barrier_inhibit,
    output logic barrier_out,
    // counter control
    input wire logic cnt_en,
    input wire logic cnt_clr,
    input wire tte_pkg::tte_evsel_t cnt_sel,
    input wire logic secure_permit,
    output logic [31:0] cnt,
    output logic cnt_ovf,
    // events
    output logic ev_tick,
    output logic ev_div,
    output logic ev_wr,
    output logic ev_rd,
    output logic ev_wrf,
    output logic ev_rdf
);
    import tte_pkg::*;

    logic [5:0] div_r, div_nxt;
    logic [5:0] ev_r, ev_nxt;
    logic bar_r, bar_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic ovf_r, ovf_nxt;
    logic hit;

    always_comb begin
        div_nxt = div_r + 6'h01;
        ev_nxt[0] = 1'b1;
        ev_nxt[1] = (div_r == `TTE_DIV_LAST);
        ev_nxt[2] = wr_txn;
        ev_nxt[3] = rd_txn;
        ev_nxt[4] = wr_alloc;
        ev_nxt[5] = rd_alloc;
        // upstream barriers always pass; own ones only without inhibit
        bar_nxt = barrier_up | (barrier_gen & ~barrier_inhibit);
        case (cnt_sel)
            TTE_EV_TICK: hit = ev_nxt[0];
            TTE_EV_DIV: hit = ev_nxt[1];
            TTE_EV_WR: hit = ev_nxt[2];
            TTE_EV_RD: hit = ev_nxt[3];
            TTE_EV_WRF: hit = ev_nxt[4];
            TTE_EV_RDF: hit = ev_nxt[5];
            default: hit = 1'b0;
        endcase
        // tick events carry no security state, traffic events do
        if (cnt_sel >= TTE_EV_WR && txn_secure && !secure_permit) begin
            hit = 1'b0;
        end
        cnt_nxt = cnt_r;
        ovf_nxt = 1'b0;
        if (cnt_clr) begin
            cnt_nxt = 32'h0000_0000;
        end else if (cnt_en && hit) begin
            cnt_nxt = cnt_r + 32'h0000_0001;
            ovf_nxt = (cnt_r == 32'hffff_ffff);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 6'h00;
            ev_r <= 6'h00;
            bar_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            ovf_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ev_r <= ev_nxt;
            bar_r <= bar_nxt;
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign ev_tick = ev_r[0];
    assign ev_div = ev_r[1];
    assign ev_wr = ev_r[2];
    assign ev_rd = ev_r[3];
    assign ev_wrf = ev_r[4];
    assign ev_rdf = ev_r[5];
    assign barrier_out = bar_r;
    assign cnt = cnt_r;
    assign cnt_ovf = ovf_r;

    sequence s_div_gap;
        !ev_div [*8];
    endsequence

    a_div_period: assert property (@(posedge clk) disable iff (!rst_n)
        ev_div |=> s_div_gap ##56 ev_div)
        else $error("divided tick not on every 64th cycle");
    a_tick_steady: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> ev_tick)
        else $error("tick event missing");
    a_wr_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        wr_txn |=> ev_wr)
        else $error("write event not signalled");
    a_rfill_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_alloc |=> ev_rdf) and (!wr_alloc |=> !ev_wrf))
        else $error("refill event mismatch");
    a_bar_inhibit: assert property (@(posedge clk) disable iff (!rst_n)
        (barrier_inhibit && barrier_gen && !barrier_up) |=> !barrier_out)
        else $error("barrier originated while inhibited");
    a_bar_forward: assert property (@(posedge clk) disable iff (!rst_n)
        barrier_up |=> barrier_out)
        else $error("upstream barrier dropped");
    a_sec_exclude: assert property (@(posedge clk) disable iff (!rst_n)
        (!cnt_clr && txn_secure && !secure_permit && cnt_sel >= TTE_EV_WR)
        |=> $stable(cnt))
        else $error("secure event counted without permit");
endmodule
`default_nettype wire

// ### bench/tte_pmu_model.sv
/*
 * far side: integrator straps and an external monitor that counts event pulses.
 * assumes event and barrier outputs are one-cycle pulses on clk.
 */
`default_nettype none
module tte_pmu_model #(
    parameter bit HALF_CLK = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // straps
    input wire logic trace_ok,
    input wire logic integ_unlock,
    output logic sec_debug_permit,
    output logic scan_hold,
    // events, index kind*2+unit: wr rd wrf rdf div barrier
    input wire logic [11:0] evs,
    output logic [15:0] cnt [12]
);
    timeunit 1ns;
    timeprecision 1ns;
    // permit forced low while integration unlock is tied high
    assign sec_debug_permit = trace_ok & ~integ_unlock;
    assign scan_hold = HALF_CLK;
    always @(posedge clk or negedge rst_n) begin
        for (int i = 0; i < 12; i++) begin
            if (!rst_n) cnt[i] <= 16'h0000;
            else if (evs[i] === 1'b1) cnt[i] <= cnt[i] + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
/*
 * self-checking bench for tte_top: apb master, random traffic, strap changes.
 * assumes one wait state answers on apb and straps settle within 4 cycles.
 */
`default_nettype none
`include "tte_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] pprot = 3'h0;
    logic pready, pslverr, err, cfg_cttw = 1'b1, dft_gate_bypass = 1'b0, integ_unlock = 1'b0;
    logic trace_ok = 1'b0, sec_debug_permit, scan_hold, cfg_normalise = 1'b1, clk_gate_en, irq;
    logic [1:0] barrier_inhibit = 2'b00, wr_txn = 2'b00, rd_txn = 2'b00, wr_alloc = 2'b00;
    logic [1:0] rd_alloc = 2'b00, txn_secure = 2'b00, barrier_gen = 2'b00, barrier_up = 2'b00;
    logic [1:0] barrier_out, ev_tick, ev_div, ev_wr, ev_rd, ev_wrf, ev_rdf;
    logic [15:0] pmu_cnt [12];
    int unsigned exp_cnt [12];
    int unsigned exp_ctr [2];
    int error_cnt = 0, num_checks = 0;

    always #50 clk = ~clk;

    tte_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_cttw(cfg_cttw),
        .dft_gate_bypass(dft_gate_bypass), .integ_unlock(integ_unlock),
        .sec_debug_permit(sec_debug_permit), .scan_hold(scan_hold),
        .cfg_normalise(cfg_normalise), .barrier_inhibit(barrier_inhibit), .wr_txn(wr_txn),
        .rd_txn(rd_txn), .wr_alloc(wr_alloc), .rd_alloc(rd_alloc), .txn_secure(txn_secure),
        .barrier_gen(barrier_gen), .barrier_up(barrier_up), .barrier_out(barrier_out),
        .clk_gate_en(clk_gate_en), .ev_tick(ev_tick), .ev_div(ev_div), .ev_wr(ev_wr),
        .ev_rd(ev_rd), .ev_wrf(ev_wrf), .ev_rdf(ev_rdf), .irq(irq));

    tte_pmu_model #(.HALF_CLK(1'b1)) pmu (.clk(clk), .rst_n(rst_n), .trace_ok(trace_ok),
        .integ_unlock(integ_unlock), .sec_debug_permit(sec_debug_permit),
        .scan_hold(scan_hold), .cnt(pmu_cnt),
        .evs({barrier_out, ev_div, ev_rdf, ev_wrf, ev_rd, ev_wr}));

    function automatic logic bar_exp(input logic up, input logic gen, input logic inh);
        return up | (gen & ~inh);
    endfunction

    function automatic logic ctr_inc(input logic txn, input logic sec, input logic permit);
        return txn & (~sec | permit);
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held from setup until the edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic ns);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pprot <= {1'b0, ns, 1'b0};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic v);
        cfg_normalise <= v;
        cfg_cttw <= v;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    // k picks the counted kind: 0 write, 2 read
    task automatic traffic(input int cycles, input logic permit, input int k);
        logic [11:0] r;
        logic [1:0] s;
        int last;
        last = -1;
        for (int c = 0; c < cycles; c++) begin
            @(negedge clk);
            chk("ev_tick", 32'h3, ev_tick);
            chk("ev_div pair", ev_div[0], ev_div[1]);
            if (ev_div[0] === 1'b1) begin
                if (last >= 0) chk("div period", 64, c - last);
                last = c;
            end
            @(posedge clk);
            r = 12'($urandom);
            s = 2'($urandom);
            {barrier_up, barrier_gen, rd_alloc, wr_alloc, rd_txn, wr_txn} <= r;
            txn_secure <= s;
            for (int i = 0; i < 8; i++) exp_cnt[i] += r[i];
            for (int u = 0; u < 2; u++) begin
                exp_cnt[10 + u] += bar_exp(r[10 + u], r[8 + u], barrier_inhibit[u]);
                exp_ctr[u] += ctr_inc(r[k + u], s[u], permit);
            end
        end
        @(posedge clk);
        {barrier_up, barrier_gen, rd_alloc, wr_alloc, rd_txn, wr_txn} <= 12'h000;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h7c03));
        for (int v = 1; v >= 0; v--) begin
            do_reset(v[0]);
            chk("clk_gate_en rst", 32'h1, clk_gate_en);
            apb(1'b0, `TTE_OFF_ID0, 32'h0, 1'b0);
            chk("id0", (v << `TTE_ID0_CTTW) | (1 << `TTE_ID0_SCAN), rd);
            apb(1'b0, `TTE_OFF_AUX, 32'h0, 1'b0);
            chk("aux", v << `TTE_AUX_NORM, rd);
            apb(1'b0, `TTE_OFF_CTRL, 32'h0, 1'b0);
            chk("ctrl rst", `TTE_CTRL_RST, rd);
        end
        $display("test reset done");
        apb(1'b1, `TTE_OFF_INTEG, 32'h0000_00a5, 1'b1);
        chk("integ wr err", 32'h1, err);
        apb(1'b0, `TTE_OFF_INTEG, 32'h0, 1'b0);
        chk("integ kept", `TTE_INTEG_RST, rd);
        apb(1'b0, `TTE_OFF_STATUS, 32'h0, 1'b0);
        chk("status", 32'h1 << `TTE_ST_REFUSED, rd);
        chk("irq masked", 32'h0, irq);
        apb(1'b1, `TTE_OFF_MASK, 32'h1 << `TTE_ST_REFUSED, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq set", 32'h1, irq);
        apb(1'b1, `TTE_OFF_STATUS, 32'h1 << `TTE_ST_REFUSED, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, irq);
        integ_unlock <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b1, `TTE_OFF_INTEG, 32'h0000_005a, 1'b1);
        apb(1'b0, `TTE_OFF_INTEG, 32'h0, 1'b1);
        chk("integ open", 32'h5a, rd);
        chk("integ err", 32'h0, err);
        apb(1'b0, 8'h40, 32'h0, 1'b0);
        chk("unmapped err", 32'h1, err);
        $display("test integration done");
        apb(1'b1, `TTE_OFF_CTRL, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        chk("gate functional", 32'h0, clk_gate_en);
        dft_gate_bypass <= 1'b1;
        repeat (4) @(posedge clk);
        chk("gate bypass", 32'h1, clk_gate_en);
        dft_gate_bypass <= 1'b0;
        integ_unlock <= 1'b0;
        $display("test gate done");
        for (int p = 0; p < 2; p++) begin
            barrier_inhibit <= p ? 2'b10 : 2'b01;
            trace_ok <= p[0];
            apb(1'b1, `TTE_OFF_CTRL, 32'h1 << `TTE_CTRL_CLR, 1'b0);
            apb(1'b1, `TTE_OFF_CTRL,
                32'h1 << `TTE_CTRL_CEN | (p ? tte_pkg::TTE_EV_RD : tte_pkg::TTE_EV_WR), 1'b0);
            exp_ctr = '{0, 0};
            traffic(300, p[0], 2 * p);
            apb(1'b0, `TTE_OFF_CNT0, 32'h0, 1'b0);
            chk("cnt0", exp_ctr[0], rd);
            apb(1'b0, `TTE_OFF_CNT1, 32'h0, 1'b0);
            chk("cnt1", exp_ctr[1], rd);
            for (int i = 0; i < 12; i++) begin
                if (i < 8 || i > 9) chk("pmu count", exp_cnt[i], pmu_cnt[i]);
            end
            $display("test traffic pass %0d done", p);
        end
        stop_test();
    end
endmodule
`default_nettype wire
